// ---- debug_command_decoder.sv ----
`timescale 1ns/10ps
module debug_command_decoder #(
  parameter logic [7:0] REV_MAJOR = 8'h01, // arbitrary value
  parameter logic [7:0] REV_MINOR = 8'h00  // arbitrary value
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // byte stream from the serial receiver
  input  wire debug_command_pkg::byte_type   rx,
  // byte stream to the serial transmitter
  output debug_command_pkg::byte_type        tx,
  input  wire logic                          tx_ready,
  // device state
  input  wire logic                          read_protect_option,
  input  wire logic                          flash_unlocked,
  input  wire logic [7:0]                    debug_status_reg,
  input  wire logic [15:0]                   program_counter,
  input  wire logic [15:0]                   baud_reload,
  input  wire logic [7:0]                    reg_rd_data,
  // cpu and memory side
  output logic                               cpu_halt,
  output logic [7:0]                         debug_control_reg,
  output logic [15:0]                        debug_down_counter,
  output debug_command_pkg::byte_type        pc_load_hi,
  output logic [15:0]                        pc_load_value,
  output logic                               pc_load,
  output logic [11:0]                        reg_rd_addr,
  output debug_command_pkg::reg_wr_type      reg_wr,
  output debug_command_pkg::pmem_wr_type     pmem_wr,
  output logic [7:0]                         cmd_other
);
  // ************************************************************
  // command sequencer
  // ************************************************************
  typedef enum logic [2:0] {
    S_CMD, S_OPND, S_DATA_IN, S_SEND, S_DATA_OUT
  } state_type;

  state_type   state_q;
  logic [7:0]  cmd_q;
  logic [2:0]  opnd_q;
  logic [31:0] opnd_data_q;
  logic [16:0] count_q;
  logic [15:0] addr_q;
  logic [1:0]  send_q;
  logic [15:0] send_word_q;
  logic        debug_on;
  logic        prot;
  logic [2:0]  opnd_need;
  logic        known;
  logic        tx_busy;

  assign debug_on = debug_control_reg[debug_command_pkg::CTL_DBG_BIT];
  assign prot     = read_protect_option;
  // a stalled response byte freezes the output side of the sequencer
  assign tx_busy  = tx.valid && !tx_ready;

  // ************************************************************
  // operand count of each command byte
  // ************************************************************
  always_comb begin
    opnd_need = 3'd0;
    known     = 1'b1;
    case (rx.data)
      debug_command_pkg::CMD_REV_RD,
      debug_command_pkg::CMD_STAT_RD,
      debug_command_pkg::CMD_CNT_RD,
      debug_command_pkg::CMD_CTL_RD,
      debug_command_pkg::CMD_PC_RD,
      debug_command_pkg::CMD_CRC_RD,
      debug_command_pkg::CMD_STEP,
      debug_command_pkg::CMD_BAUD_RD: opnd_need = 3'd0;
      debug_command_pkg::CMD_CTL_WR,
      debug_command_pkg::CMD_STUFF,
      debug_command_pkg::CMD_EXEC: opnd_need = 3'd1;
      debug_command_pkg::CMD_CNT_WR,
      debug_command_pkg::CMD_PC_WR: opnd_need = 3'd2;
      debug_command_pkg::CMD_REG_WR,
      debug_command_pkg::CMD_REG_RD: opnd_need = 3'd3;
      debug_command_pkg::CMD_PMEM_WR,
      debug_command_pkg::CMD_PMEM_RD,
      debug_command_pkg::CMD_DMEM_WR,
      debug_command_pkg::CMD_DMEM_RD: opnd_need = 3'd4;
      default: known = 1'b0;
    endcase
  end

  // ************************************************************
  // access gate
  // ************************************************************
  // gated commands still walk their framing; only the effects are dropped
  logic allowed;
  always_comb begin
    case (cmd_q)
      debug_command_pkg::CMD_REV_RD,
      debug_command_pkg::CMD_STAT_RD,
      debug_command_pkg::CMD_CTL_WR,
      debug_command_pkg::CMD_CTL_RD: allowed = 1'b1;
      debug_command_pkg::CMD_PC_WR,
      debug_command_pkg::CMD_PC_RD,
      debug_command_pkg::CMD_PMEM_WR,
      debug_command_pkg::CMD_PMEM_RD,
      debug_command_pkg::CMD_DMEM_WR,
      debug_command_pkg::CMD_DMEM_RD,
      debug_command_pkg::CMD_STEP,
      debug_command_pkg::CMD_STUFF,
      debug_command_pkg::CMD_EXEC: allowed = debug_on && !prot;
      default: allowed = debug_on;
    endcase
  end

  logic [7:0] op_last;
  assign op_last = rx.data;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q     <= S_CMD;
      cmd_q       <= 8'h00;
      opnd_q      <= 3'd0;
      opnd_data_q <= 32'h0000_0000;
      count_q     <= 17'd0;
      addr_q      <= 16'h0000;
      send_q      <= 2'd0;
      send_word_q <= 16'h0000;
    end else begin
      case (state_q)
        S_CMD: begin
          if (rx.valid && known) begin
            cmd_q  <= rx.data;
            opnd_q <= opnd_need;
            state_q <= (opnd_need == 3'd0) ? S_SEND : S_OPND;
          end
        end
        S_OPND: begin
          if (rx.valid) begin
            opnd_data_q <= {opnd_data_q[23:0], op_last};
            opnd_q      <= opnd_q - 3'd1;
            if (opnd_q == 3'd1) begin
              state_q <= S_SEND;
            end
          end
        end
        S_SEND: begin
          // one decode cycle after the last operand
          state_q <= S_CMD;
          send_q  <= 2'd0;
          case (cmd_q)
            debug_command_pkg::CMD_REV_RD: begin
              send_word_q <= {REV_MAJOR, REV_MINOR};
              send_q      <= 2'd2;
              state_q     <= S_DATA_OUT;
            end
            debug_command_pkg::CMD_STAT_RD,
            debug_command_pkg::CMD_CTL_RD: begin
              send_word_q <= {(cmd_q == debug_command_pkg::CMD_STAT_RD) ?
                              debug_status_reg : debug_control_reg,
                              8'h00};
              send_q      <= 2'd1;
              state_q     <= S_DATA_OUT;
            end
            debug_command_pkg::CMD_CNT_RD: begin
              send_word_q <= debug_on ? ~debug_down_counter :
                             16'hFFFF;
              send_q      <= 2'd2;
              state_q     <= S_DATA_OUT;
            end
            debug_command_pkg::CMD_PC_RD: begin
              send_word_q <= allowed ? program_counter : 16'hFFFF;
              send_q      <= 2'd2;
              state_q     <= S_DATA_OUT;
            end
            debug_command_pkg::CMD_BAUD_RD: begin
              send_word_q <= allowed ? baud_reload : 16'hFFFF;
              send_q      <= 2'd2;
              state_q     <= S_DATA_OUT;
            end
            debug_command_pkg::CMD_REG_WR,
            debug_command_pkg::CMD_REG_RD: begin
              addr_q  <= {4'h0, opnd_data_q[19:8]};
              count_q <= (opnd_data_q[7:0] == 8'h00) ? 17'd256 :
                         {9'd0, opnd_data_q[7:0]};
              state_q <= (cmd_q == debug_command_pkg::CMD_REG_WR) ?
                         S_DATA_IN : S_DATA_OUT;
            end
            debug_command_pkg::CMD_PMEM_WR,
            debug_command_pkg::CMD_DMEM_WR: begin
              addr_q  <= opnd_data_q[31:16];
              count_q <= (opnd_data_q[15:0] == 16'h0000) ? 17'h10000 :
                         {1'b0, opnd_data_q[15:0]};
              state_q <= S_DATA_IN;
            end
            default: state_q <= S_CMD;
          endcase
        end
        S_DATA_IN: begin
          // gated data is still counted so the next command byte lines up
          if (rx.valid) begin
            addr_q  <= addr_q + 16'h0001;
            count_q <= count_q - 17'd1;
            if (count_q == 17'd1) begin
              state_q <= S_CMD;
            end
          end
        end
        S_DATA_OUT: begin
          if (!tx_busy) begin
            if (cmd_q == debug_command_pkg::CMD_REG_RD) begin
              addr_q  <= addr_q + 16'h0001;
              count_q <= count_q - 17'd1;
              if (count_q == 17'd1) begin
                state_q <= S_CMD;
              end
            end else begin
              send_word_q <= {send_word_q[7:0], 8'h00};
              send_q      <= send_q - 2'd1;
              if (send_q == 2'd1) begin
                state_q <= S_CMD;
              end
            end
          end
        end
        default: state_q <= S_CMD;
      endcase
    end
  end

  // ************************************************************
  // response byte
  // ************************************************************
  logic       reg_ram;
  logic [7:0] reg_byte;
  // limitation: only the top page of the register file counts as peripheral
  assign reg_ram  = addr_q[11:0] < debug_command_pkg::PERIPH_BASE;
  assign reg_byte = (!debug_on || (prot && reg_ram)) ?
                    debug_command_pkg::BLANK_BYTE : reg_rd_data;
  assign reg_rd_addr = addr_q[11:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx <= '0;
    end else if (!tx_busy) begin
      // valid and data only move together, never while stalled
      tx.valid <= (state_q == S_DATA_OUT);
      tx.data  <= (cmd_q == debug_command_pkg::CMD_REG_RD) ? reg_byte :
                  send_word_q[15:8];
    end
  end

  // ************************************************************
  // register effects
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      debug_control_reg  <= debug_command_pkg::CTL_RESET;
      debug_down_counter <= debug_command_pkg::CNT_RESET;
      pc_load            <= 1'b0;
      pc_load_value      <= 16'h0000;
      cpu_halt           <= 1'b0;
    end else begin
      pc_load  <= 1'b0;
      cpu_halt <= debug_control_reg[debug_command_pkg::CTL_DBG_BIT];
      if (state_q == S_SEND) begin
        if (cmd_q == debug_command_pkg::CMD_CTL_WR) begin
          debug_control_reg <= opnd_data_q[7:0];
        end
        if (cmd_q == debug_command_pkg::CMD_CNT_WR && debug_on) begin
          debug_down_counter <= opnd_data_q[15:0];
        end
        if (cmd_q == debug_command_pkg::CMD_PC_WR && allowed) begin
          pc_load       <= 1'b1;
          pc_load_value <= opnd_data_q[15:0];
        end
      end
    end
  end

  assign pc_load_hi = '{valid: pc_load, data: pc_load_value[15:8]};

  // ************************************************************
  // memory write strobes
  // ************************************************************
  logic in_byte;
  assign in_byte = (state_q == S_DATA_IN) && rx.valid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_wr    <= '0;
      pmem_wr   <= '0;
      cmd_other <= 8'h00;
    end else begin
      reg_wr.valid <= in_byte && cmd_q == debug_command_pkg::CMD_REG_WR &&
                      debug_on && !(prot && reg_ram);
      reg_wr.addr  <= addr_q[11:0];
      reg_wr.data  <= rx.data;
      pmem_wr.valid <= in_byte && cmd_q == debug_command_pkg::CMD_PMEM_WR &&
                       allowed && flash_unlocked;
      pmem_wr.addr  <= addr_q;
      pmem_wr.data  <= rx.data;
      cmd_other <= (state_q == S_SEND && allowed) ? cmd_q : 8'h00;
    end
  end
endmodule

// ---- debug_command_pkg.sv ----
package debug_command_pkg;
  localparam logic [7:0] CMD_REV_RD    = 8'h00;
  localparam logic [7:0] CMD_CNT_WR    = 8'h01;
  localparam logic [7:0] CMD_STAT_RD   = 8'h02;
  localparam logic [7:0] CMD_CNT_RD    = 8'h03;
  localparam logic [7:0] CMD_CTL_WR    = 8'h04;
  localparam logic [7:0] CMD_CTL_RD    = 8'h05;
  localparam logic [7:0] CMD_PC_WR     = 8'h06;
  localparam logic [7:0] CMD_PC_RD     = 8'h07;
  localparam logic [7:0] CMD_REG_WR    = 8'h08;
  localparam logic [7:0] CMD_REG_RD    = 8'h09;
  localparam logic [7:0] CMD_PMEM_WR   = 8'h0A;
  localparam logic [7:0] CMD_PMEM_RD   = 8'h0B;
  localparam logic [7:0] CMD_DMEM_WR   = 8'h0C;
  localparam logic [7:0] CMD_DMEM_RD   = 8'h0D;
  localparam logic [7:0] CMD_CRC_RD    = 8'h0E;
  localparam logic [7:0] CMD_STEP      = 8'h10;
  localparam logic [7:0] CMD_STUFF     = 8'h11;
  localparam logic [7:0] CMD_EXEC      = 8'h12;
  localparam logic [7:0] CMD_BAUD_RD   = 8'h1B;
  localparam logic [7:0] BLANK_BYTE    = 8'hFF;
  localparam logic [7:0] CTL_RESET     = 8'h00;
  localparam logic [15:0] CNT_RESET    = 16'h0000;
  localparam int         CTL_DBG_BIT   = 7;
  // peripheral registers sit in the top page of the register file
  localparam logic [11:0] PERIPH_BASE  = 12'hF00;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_type;

  typedef struct packed {
    logic        valid;
    logic [11:0] addr;
    logic [7:0]  data;
  } reg_wr_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
  } pmem_wr_type;
endpackage

// ---- debug_command_decoder_chk.sv ----
`timescale 1ns/10ps
// ******
// debug command checker
// ******
module debug_command_decoder_chk (
  input wire logic                           clk,
  input wire logic                           rst,
  input wire debug_command_pkg::byte_type    rx,
  input wire debug_command_pkg::byte_type    tx,
  input wire logic                           tx_ready,
  input wire logic                           read_protect_option,
  input wire logic                           flash_unlocked,
  input wire logic                           cpu_halt,
  input wire logic [7:0]                     debug_control_reg,
  input wire logic [15:0]                    debug_down_counter,
  input wire logic                           pc_load,
  input wire debug_command_pkg::reg_wr_type  reg_wr,
  input wire debug_command_pkg::pmem_wr_type pmem_wr
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic debug_on = debug_control_reg[debug_command_pkg::CTL_DBG_BIT];
  a_halt_follows_mode: assert property (
    debug_on |=> cpu_halt) else $error("cpu not halted in debug mode");
  a_run_follows_mode: assert property (
    !debug_on |=> !cpu_halt) else $error("cpu halted outside debug mode");
  a_tx_hold_stall: assert property (
    tx.valid && !tx_ready |=> tx.valid && $stable(tx.data))
    else $error("response byte dropped while stalled");
  a_cnt_debug_only: assert property (
    $changed(debug_down_counter) |-> $past(debug_on))
    else $error("counter written outside debug mode");
  a_ctl_host_write: assert property (
    $changed(debug_control_reg) |-> $past(rx.valid) || $past(rx.valid, 2))
    else $error("control changed without a host byte");
  a_pc_load_gate: assert property (
    pc_load |-> debug_on && !read_protect_option)
    else $error("pc loaded while gated");
  a_reg_wr_gate: assert property (
    reg_wr.valid |-> debug_on) else $error("register write outside debug");
  a_reg_wr_periph: assert property (
    reg_wr.valid && read_protect_option
      |-> reg_wr.addr >= debug_command_pkg::PERIPH_BASE)
    else $error("protected ram written");
  a_pmem_wr_gate: assert property (
    pmem_wr.valid |-> debug_on && flash_unlocked && !read_protect_option)
    else $error("program memory written while gated");
  a_pmem_wr_paced: assert property (
    pmem_wr.valid |-> $past(rx.valid) || $past(rx.valid, 2))
    else $error("program write without a data byte");
  c_pmem_write: cover property (pmem_wr.valid);
  c_periph_write: cover property (reg_wr.valid && read_protect_option);
  c_tx_stall: cover property (tx.valid && !tx_ready);
endmodule
bind debug_command_decoder debug_command_decoder_chk chk (
  .clk(clk), .rst(rst), .rx(rx), .tx(tx), .tx_ready(tx_ready),
  .read_protect_option(read_protect_option),
  .flash_unlocked(flash_unlocked), .cpu_halt(cpu_halt),
  .debug_control_reg(debug_control_reg),
  .debug_down_counter(debug_down_counter), .pc_load(pc_load),
  .reg_wr(reg_wr), .pmem_wr(pmem_wr));

// ---- debug_host_model.sv ----
`timescale 1ns/10ps
// ******
// debug host seen from the byte side of the link
// ******
module debug_host_model (
  // clock
  input  wire logic                   clk,
  // byte streams
  output debug_command_pkg::byte_type rx,
  output logic                        tx_ready
);
  initial begin
    rx = '0;
    tx_ready = 1'b0;
  end
  // random stalls exercise the hold of each response byte
  always @(negedge clk) tx_ready <= ($urandom % 3) != 0;
  // bytes go out one per call, upper operand byte first
  task automatic put(input logic [7:0] b);
    @(negedge clk);
    rx <= '{valid: 1'b1, data: b};
    @(negedge clk);
    // a released line shows no stale byte
    rx <= '{valid: 1'b0, data: ~b};
    repeat ($urandom % 3) @(negedge clk);
  endtask
endmodule

// ---- debug_command_decoder_tb.sv ----
`timescale 1ns/10ps
// ******
// bench
// ******
module debug_command_decoder_tb;
  localparam logic [7:0] MAJ = 8'h3C;
  localparam logic [7:0] MIN = 8'hA5;
  logic                           clk, rst, tx_ready, cpu_halt, pc_load;
  logic                           read_protect_option, flash_unlocked;
  logic [7:0]                     debug_status_reg, reg_rd_data;
  logic [7:0]                     debug_control_reg;
  logic [15:0]                    program_counter, baud_reload, v;
  logic [15:0]                    debug_down_counter, pc_load_value;
  logic [11:0]                    reg_rd_addr;
  debug_command_pkg::byte_type    rx, tx, pc_load_hi;
  debug_command_pkg::reg_wr_type  reg_wr;
  debug_command_pkg::pmem_wr_type pmem_wr;
  logic [7:0]                     cq[$], eq[$];
  logic [7:0]                     cmd_other, last_other;
  logic [23:0]                    wq[$];
  int                             miscompares, comparisons, i;
  int                             reg_writes, pmem_writes;
  debug_host_model host (.clk(clk), .rx(rx), .tx_ready(tx_ready));
  debug_command_decoder #(.REV_MAJOR(MAJ), .REV_MINOR(MIN)) dut (
    .clk(clk), .rst(rst), .rx(rx), .tx(tx), .tx_ready(tx_ready),
    .read_protect_option(read_protect_option),
    .flash_unlocked(flash_unlocked), .debug_status_reg(debug_status_reg),
    .program_counter(program_counter), .baud_reload(baud_reload),
    .reg_rd_data(reg_rd_data), .cpu_halt(cpu_halt),
    .debug_control_reg(debug_control_reg),
    .debug_down_counter(debug_down_counter), .pc_load_hi(pc_load_hi),
    .pc_load_value(pc_load_value), .pc_load(pc_load),
    .reg_rd_addr(reg_rd_addr), .reg_wr(reg_wr), .pmem_wr(pmem_wr),
    .cmd_other(cmd_other));
  assign reg_rd_data = reg_rd_addr[7:0] ^ 8'h5A;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic e16(input logic [15:0] x);
    eq.push_back(x[15:8]);
    eq.push_back(x[7:0]);
  endtask
  // every write strobe must match the oldest expected address and data
  task automatic wr_check(input logic [23:0] got);
    logic [23:0] want;
    want = (wq.size() != 0) ? wq.pop_front() : 'x;
    comparisons++;
    if (got !== want) begin
      miscompares++;
      $display("[FAIL] %0t write %h expected %h", $time, got, want);
    end
  endtask
  // the next command waits for the whole response
  task automatic go;
    int n;
    last_other = 8'h00;
    foreach (cq[k]) host.put(cq[k]);
    cq = {};
    n = 0;
    while ((eq.size() != 0 || wq.size() != 0 || tx.valid !== 1'b0) &&
           n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n == 2000) begin
      miscompares++;
      summarize();
    end
    repeat (4) @(negedge clk);
  endtask
  always @(posedge clk) begin
    if (cmd_other !== 8'h00) last_other = cmd_other;
    if (reg_wr.valid === 1'b1) begin
      reg_writes++;
      wr_check({4'h0, reg_wr.addr, reg_wr.data});
    end
    if (pmem_wr.valid === 1'b1) begin
      pmem_writes++;
      wr_check({pmem_wr.addr, pmem_wr.data});
    end
    if (!rst && tx.valid === 1'b1 && tx_ready) begin
      if (eq.size() == 0) begin
        miscompares++;
        $display("[FAIL] %0t unexpected response byte", $time);
      end else
        check({8'h00, tx.data}, {8'h00, eq.pop_front()});
    end
  end
  initial begin
    i = $urandom(32'h60E47AA5);
    rst = 1'b1;
    read_protect_option = 1'b0;
    flash_unlocked = 1'b0;
    debug_status_reg = 8'($urandom);
    program_counter = 16'($urandom);
    baud_reload = 16'($urandom);
    repeat (8) @(negedge clk);
    rst = 1'b0;
    // normal mode
    e16({MAJ, MIN});
    cq = '{8'h00};
    go();
    eq.push_back(debug_status_reg);
    cq = '{8'h02};
    go();
    e16(16'hFFFF);
    cq = '{8'h03};
    go();
    e16(16'hFFFF);
    cq = '{8'h07};
    go();
    cq = '{8'h01, 8'h12, 8'h34};
    go();
    check(debug_down_counter, 16'h0000);
    cq = '{8'h0F};
    go();
    cq = '{8'h12, 8'h00};
    go();
    check({8'h00, last_other}, 16'h0000);
    eq.push_back(8'h00);
    cq = '{8'h05};
    go();
    e16(16'hFFFF);
    cq = '{8'h09, 8'h00, 8'h40, 8'h02};
    go();
    cq = '{8'h08, 8'h0F, 8'h10, 8'h01, 8'hAA};
    go();
    check(16'(reg_writes), 16'h0000);
    e16(16'hFFFF);
    cq = '{8'h1B};
    go();
    // enter debug mode
    cq = '{8'h04, 8'h80};
    go();
    check({15'h0000, cpu_halt}, 16'h0001);
    eq.push_back(8'h80);
    cq = '{8'h05};
    go();
    v = 16'($urandom);
    cq = '{8'h01, v[15:8], v[7:0]};
    go();
    e16(~v);
    cq = '{8'h03};
    go();
    e16(program_counter);
    cq = '{8'h07};
    go();
    v = 16'($urandom);
    cq = '{8'h06, v[15:8], v[7:0]};
    go();
    check(pc_load_value, v);
    check({8'h00, pc_load_hi.data}, {8'h00, v[15:8]});
    cq = '{8'h11, 8'h3C};
    go();
    check({8'h00, last_other}, 16'h0011);
    for (i = 0; i < 256; i++) eq.push_back(8'(i) ^ 8'h5A);
    cq = '{8'h09, 8'h00, 8'h00, 8'h00};
    go();
    wq.push_back({16'h0020, 8'h11});
    wq.push_back({16'h0021, 8'h22});
    cq = '{8'h08, 8'h00, 8'h20, 8'h02, 8'h11, 8'h22};
    go();
    check(16'(reg_writes), 16'h0002);
    cq = '{8'h0A, 8'h01, 8'h00, 8'h00, 8'h02, 8'h55, 8'h66};
    go();
    check(16'(pmem_writes), 16'h0000);
    flash_unlocked = 1'b1;
    go();
    check(16'(pmem_writes), 16'h0000);
    wq.push_back({16'h0100, 8'h55});
    wq.push_back({16'h0101, 8'h66});
    cq = '{8'h0A, 8'h01, 8'h00, 8'h00, 8'h02, 8'h55, 8'h66};
    go();
    check(16'(pmem_writes), 16'h0002);
    // read protection
    read_protect_option = 1'b1;
    e16(16'hFFFF);
    cq = '{8'h07};
    go();
    cq = '{8'h0A, 8'h01, 8'h00, 8'h00, 8'h01, 8'h77};
    go();
    check(16'(pmem_writes), 16'h0002);
    cq = '{8'h06, 8'h00, 8'h00};
    go();
    check(pc_load_value, v);
    cq = '{8'h0D, 8'h00, 8'h00, 8'h00, 8'h01};
    go();
    eq.push_back(debug_status_reg);
    cq = '{8'h02};
    go();
    cq = '{8'h08, 8'h00, 8'h20, 8'h01, 8'h33};
    go();
    wq.push_back({16'h0F00, 8'h44});
    cq = '{8'h08, 8'h0F, 8'h00, 8'h01, 8'h44};
    go();
    check(16'(reg_writes), 16'h0003);
    cq = '{8'h10};
    go();
    check({8'h00, last_other}, 16'h0000);
    cq = '{8'h0E};
    go();
    check({8'h00, last_other}, 16'h000E);
    eq.push_back(8'hFF);
    cq = '{8'h09, 8'h00, 8'h40, 8'h01};
    go();
    eq.push_back(8'h05 ^ 8'h5A);
    cq = '{8'h09, 8'h0F, 8'h05, 8'h01};
    go();
    e16(baud_reload);
    cq = '{8'h1B};
    go();
    cq = '{8'h04, 8'h00};
    go();
    check({15'h0000, cpu_halt}, 16'h0000);
    summarize();
  end
endmodule
